// File: rtl/pdc_regs.svh
// Offsets, field positions, reset values and size limits of the port device control register.
// Assumes inclusion by bare name from any file of this block.
`ifndef PDC_REGS_SVH
`define PDC_REGS_SVH

// Configuration offset and function of the register
`define PDC_OFF_DEVCTRL 12'h074
`define PDC_PORT_FUNC 3'h0

// Field positions inside the 16-bit register
`define PDC_RSV_BIT 15
`define PDC_RRS_MSB 14
`define PDC_RRS_LSB 12
`define PDC_NSP_BIT 11
`define PDC_AUX_BIT 10
`define PDC_PHF_BIT 9

// Reset and fixed values
`define PDC_RRS_RST 3'h5
`define PDC_NSP_RST 1'b1
`define PDC_AUX_RST 1'b0
`define PDC_PHF_VAL 1'b0
`define PDC_RSV_VAL 1'b0

// Read-request size encodings and the outbound hardware cap in bytes
`define PDC_RRS_128 3'h0
`define PDC_RRS_4096 3'h5
`define PDC_RRS_BYTES_MIN 13'h080
`define PDC_HW_RD_MAX_BYTES 13'h040

`endif

// File: rtl/pdc_pkg.sv
// Types shared by the port device control block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package pdc_pkg;

    // Read splitter states
    typedef enum logic [0:0] {
        PDC_IDLE = 1'b0,
        PDC_SEND = 1'b1
    } pdc_split_e;

    // Control register state
    typedef struct packed {
        logic [2:0] rrs;
        logic ns_permit;
        logic ack;
        logic [31:0] rdata;
        logic rx_valid;
        logic [1:0] rx_attr;
    } pdc_ctl_s;

    // Read splitter state
    typedef struct packed {
        pdc_split_e st;
        logic [31:0] addr;
        logic [12:0] rem;
        logic ns_ok;
        logic tx_valid;
        logic [31:0] tx_addr;
        logic [6:0] tx_len;
        logic tx_ns;
    } pdc_split_s;

    // Sticky auxiliary power state
    typedef struct packed {
        logic aux_en;
        logic [2:0] alloc;
    } pdc_aux_s;

endpackage : pdc_pkg

`default_nettype wire

// File: rtl/pdc_aux_power.sv
// Sticky auxiliary power enable and the resulting aux power allocation.
// Assumes a power-on reset that is separate from the ordinary port reset.
`include "pdc_regs.svh"
`default_nettype none

module pdc_aux_power (
    input wire logic clk_sys,
    input wire logic nrst_pwr,
    input wire logic wr_en,
    input wire logic wr_val,
    input wire logic [2:0] aux_current,
    output logic aux_en,
    output logic [2:0] aux_alloc
);

    pdc_pkg::pdc_aux_s q, d;

    // Next state: write updates enable, allocation follows requested current while enabled and is zero otherwise
    always_comb begin
        d = q;
        if (wr_en) begin
            d.aux_en = wr_val;
        end
        d.alloc = q.aux_en ? aux_current : 3'h0;
    end

    // Only power-on reset clears this state
    always_ff @(posedge clk_sys or negedge nrst_pwr) begin
        if (!nrst_pwr) begin
            q <= '{aux_en: `PDC_AUX_RST, alloc: 3'h0};
        end else begin
            q <= d;
        end
    end

    assign aux_en = q.aux_en;
    assign aux_alloc = q.alloc;

endmodule : pdc_aux_power

`default_nettype wire

// File: rtl/pdc_read_split.sv
// Splits outbound read requests into pieces no larger than the allowed size.
// Assumes requests of 1 to 4096 bytes and a sink that may stall with ready.
`include "pdc_regs.svh"
`default_nettype none

module pdc_read_split (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [2:0] rrs,
    input wire logic ns_permit,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [31:0] req_addr,
    input wire logic [12:0] req_len,
    input wire logic req_ns_ok,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [31:0] tx_addr,
    output logic [6:0] tx_len,
    output logic tx_ns
);

    pdc_pkg::pdc_split_s q, d;

    // Byte size of a read-request size code; reserved codes act as smallest
    function automatic logic [12:0] rrs_bytes(input logic [2:0] code);
        logic [12:0] b;
        b = `PDC_RRS_BYTES_MIN;
        if (code <= `PDC_RRS_4096) begin
            b = `PDC_RRS_BYTES_MIN << code;
        end
        return b;
    endfunction : rrs_bytes

    logic [12:0] eff;
    logic [12:0] room;
    logic [12:0] chunk;

    // Piece size: programmed limit, hardware cap, and no boundary crossing
    always_comb begin
        eff = rrs_bytes(rrs);
        if (`PDC_HW_RD_MAX_BYTES < eff) begin
            eff = `PDC_HW_RD_MAX_BYTES;
        end
        room = eff - (q.addr[12:0] & (eff - 13'h001));
        chunk = (q.rem < room) ? q.rem : room;
    end

    // Next state
    always_comb begin
        d = q;
        case (q.st)
            pdc_pkg::PDC_IDLE: begin
                if (q.tx_valid && tx_ready) begin
                    d.tx_valid = 1'b0;
                end
                if (req_valid && req_len != 13'h000) begin
                    d.addr = req_addr;
                    d.rem = req_len;
                    d.ns_ok = req_ns_ok;
                    d.st = pdc_pkg::PDC_SEND;
                end
            end
            pdc_pkg::PDC_SEND: begin
                if (!q.tx_valid || tx_ready) begin
                    d.tx_valid = 1'b1;
                    d.tx_addr = q.addr;
                    d.tx_len = chunk[6:0];
                    d.tx_ns = q.ns_ok & ns_permit;
                    d.addr = q.addr + {19'h0, chunk};
                    d.rem = q.rem - chunk;
                    if (q.rem == chunk) begin
                        d.st = pdc_pkg::PDC_IDLE;
                    end
                end
            end
            default: begin
                d.st = pdc_pkg::PDC_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign req_ready = (q.st == pdc_pkg::PDC_IDLE);
    assign tx_valid = q.tx_valid;
    assign tx_addr = q.tx_addr;
    assign tx_len = q.tx_len;
    assign tx_ns = q.tx_ns;

endmodule : pdc_read_split

`default_nettype wire

// File: rtl/pdc_port_devctrl.sv
// Port device control register (bits 15 to 9) with its outbound read shaping.
// Assumes configuration requests and traffic on CLK_SYS; NRST_PWR is power-on reset.
`include "pdc_regs.svh"
`default_nettype none

module pdc_port_devctrl #(
    parameter logic [4:0] PORT_DEV = 5'h02
) (
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic NRST_PWR,
    input wire logic CFG_REQ,
    input wire logic CFG_WE,
    input wire logic [4:0] CFG_DEV,
    input wire logic [2:0] CFG_FUNC,
    input wire logic [11:0] CFG_OFFSET,
    input wire logic [3:0] CFG_BE,
    input wire logic [31:0] CFG_WDATA,
    output logic CFG_ACK,
    output logic [31:0] CFG_RDATA,
    output logic [2:0] READ_REQUEST_SIZE_LIMIT,
    output logic NO_SNOOP_PERMIT,
    output logic AUX_POWER_ENABLE,
    output logic PHANTOM_FUNCTION_ENABLE,
    input wire logic [2:0] AUX_CURRENT,
    output logic [2:0] AUX_POWER_ALLOC,
    input wire logic RD_REQ_VALID,
    output logic RD_REQ_READY,
    input wire logic [31:0] RD_REQ_ADDR,
    input wire logic [12:0] RD_REQ_LEN,
    input wire logic RD_REQ_NS_OK,
    output logic TX_VALID,
    input wire logic TX_READY,
    output logic [31:0] TX_ADDR,
    output logic [6:0] TX_LEN,
    output logic TX_NO_SNOOP,
    output logic TX_SNOOP,
    input wire logic RX_VALID,
    input wire logic [1:0] RX_ATTR_IN,
    output logic RX_VALID_OUT,
    output logic [1:0] RX_ATTR_OUT
);

    pdc_pkg::pdc_ctl_s q, d;

    logic hit;
    logic wr_hi;
    logic aux_en;

    // Decode: this port's device number, function 0, dword holding 74h
    assign hit = (CFG_DEV == PORT_DEV) && (CFG_FUNC == `PDC_PORT_FUNC)
        && (CFG_OFFSET[11:2] == 10'(`PDC_OFF_DEVCTRL >> 2));
    // Write strobe for the byte lane holding bits 15:8
    assign wr_hi = CFG_REQ && CFG_WE && hit && CFG_BE[1];

    // Register image as read back; low byte fields belong elsewhere
    function automatic logic [31:0] image(
        input logic [2:0] rrs,
        input logic nsp,
        input logic aux
    );
        logic [31:0] v;
        v = 32'h0;
        v[`PDC_RSV_BIT] = `PDC_RSV_VAL;
        v[`PDC_RRS_MSB:`PDC_RRS_LSB] = rrs;
        v[`PDC_NSP_BIT] = nsp;
        v[`PDC_AUX_BIT] = aux;
        v[`PDC_PHF_BIT] = `PDC_PHF_VAL;
        return v;
    endfunction : image

    // Next state: field writes, read answer, received attribute pass-through
    always_comb begin
        d = q;
        d.ack = CFG_REQ;
        d.rdata = 32'h0;
        if (wr_hi) begin
            d.rrs = CFG_WDATA[`PDC_RRS_MSB:`PDC_RRS_LSB];
            d.ns_permit = CFG_WDATA[`PDC_NSP_BIT];
        end
        if (CFG_REQ && !CFG_WE && hit) begin
            d.rdata = image(q.rrs, q.ns_permit, aux_en);
        end
        // Attribute bits are copied, never set or cleared here
        d.rx_valid = RX_VALID;
        if (RX_VALID) begin
            d.rx_attr = RX_ATTR_IN;
        end
    end

    // Ordinary port reset restores the size limit and no-snoop permit fields
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            q <= '{
                rrs: `PDC_RRS_RST,
                ns_permit: `PDC_NSP_RST,
                ack: 1'b0,
                rdata: 32'h0,
                rx_valid: 1'b0,
                rx_attr: 2'h0
            };
        end else begin
            q <= d;
        end
    end

    // Sticky aux power enable on the power-on reset
    pdc_aux_power u_aux (
        .clk_sys(CLK_SYS),
        .nrst_pwr(NRST_PWR),
        .wr_en(wr_hi),
        .wr_val(CFG_WDATA[`PDC_AUX_BIT]),
        .aux_current(AUX_CURRENT),
        .aux_en(aux_en),
        .aux_alloc(AUX_POWER_ALLOC)
    );

    // Outbound read shaping
    pdc_read_split u_split (
        .clk_sys(CLK_SYS),
        .nrst(NRST),
        .rrs(q.rrs),
        .ns_permit(q.ns_permit),
        .req_valid(RD_REQ_VALID),
        .req_ready(RD_REQ_READY),
        .req_addr(RD_REQ_ADDR),
        .req_len(RD_REQ_LEN),
        .req_ns_ok(RD_REQ_NS_OK),
        .tx_valid(TX_VALID),
        .tx_ready(TX_READY),
        .tx_addr(TX_ADDR),
        .tx_len(TX_LEN),
        .tx_ns(TX_NO_SNOOP)
    );

    // Outputs
    assign CFG_ACK = q.ack;
    assign CFG_RDATA = q.rdata;
    assign READ_REQUEST_SIZE_LIMIT = q.rrs;
    assign NO_SNOOP_PERMIT = q.ns_permit;
    assign AUX_POWER_ENABLE = aux_en;
    assign PHANTOM_FUNCTION_ENABLE = `PDC_PHF_VAL;
    assign TX_SNOOP = 1'b0;
    assign RX_VALID_OUT = q.rx_valid;
    assign RX_ATTR_OUT = q.rx_attr;

    // Checks on this port's own behaviour
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);

    // Size limit in bytes, mirrored for the checks
    logic [12:0] lim_bytes;
    always_comb begin
        lim_bytes = `PDC_RRS_BYTES_MIN;
        if (q.rrs <= `PDC_RRS_4096) begin
            lim_bytes = `PDC_RRS_BYTES_MIN << q.rrs;
        end
    end

    sequence cfg_wr_hi_s;
        CFG_REQ && CFG_WE && hit && CFG_BE[1];
    endsequence

    sequence cfg_rd_hit_s;
        CFG_REQ && !CFG_WE && hit;
    endsequence

    // Accepted read request with bytes to send
    sequence rd_take_s;
        RD_REQ_VALID && RD_REQ_READY && RD_REQ_LEN != 13'h000;
    endsequence

    // Zero-length request, dropped on acceptance
    sequence rd_zero_s;
        RD_REQ_VALID && RD_REQ_READY && RD_REQ_LEN == 13'h000;
    endsequence

    // Aux enable seen on two edges running, either level
    sequence aux_on2_s;
        AUX_POWER_ENABLE ##1 AUX_POWER_ENABLE;
    endsequence

    sequence aux_off2_s;
        !AUX_POWER_ENABLE ##1 !AUX_POWER_ENABLE;
    endsequence

    cfg_ack_a: assert property (CFG_REQ |=> CFG_ACK)
        else $error("configuration request not acknowledged");

    miss_zero_a: assert property ((CFG_REQ && !hit) |=> CFG_RDATA == 32'h0)
        else $error("unmapped configuration read returned data");

    rrs_write_a: assert property (
        cfg_wr_hi_s |=> READ_REQUEST_SIZE_LIMIT == $past(CFG_WDATA[14:12]))
        else $error("size limit did not take written value");

    rrs_hold_a: assert property (
        !(CFG_REQ && CFG_WE) |=> $stable(READ_REQUEST_SIZE_LIMIT))
        else $error("size limit changed without a write");

    rd_back_a: assert property (
        cfg_rd_hit_s ##1 1'b1 |-> CFG_RDATA[14:12] == $past(READ_REQUEST_SIZE_LIMIT)
        && CFG_RDATA[11] == $past(NO_SNOOP_PERMIT)
        && CFG_RDATA[10] == $past(AUX_POWER_ENABLE))
        else $error("read back does not match fields");

    tx_limit_a: assert property (TX_VALID |-> {6'h0, TX_LEN} <= lim_bytes)
        else $error("outbound read exceeds programmed limit");

    tx_cap_a: assert property (TX_VALID |-> TX_LEN <= 7'h40 && TX_LEN != 7'h0)
        else $error("outbound read exceeds hardware cap");

    tx_hold_a: assert property (
        (TX_VALID && !TX_READY) |=> TX_VALID && $stable(TX_LEN) && $stable(TX_ADDR))
        else $error("stalled outbound read changed");

    ns_gate_a: assert property (
        (TX_VALID && TX_NO_SNOOP && $changed(TX_ADDR)) |-> $past(NO_SNOOP_PERMIT))
        else $error("no-snoop set without permission");

    rx_pass_a: assert property (
        RX_VALID |=> RX_VALID_OUT && RX_ATTR_OUT == $past(RX_ATTR_IN))
        else $error("received attribute altered");

    no_snoop_out_a: assert property (TX_VALID |-> !TX_SNOOP)
        else $error("outbound traffic snooped");

    aux_alloc_a: assert property (
        aux_on2_s |-> AUX_POWER_ALLOC == $past(AUX_CURRENT))
        else $error("aux allocation does not follow requested current");

    aux_off_a: assert property (
        aux_off2_s |-> AUX_POWER_ALLOC == 3'h0)
        else $error("aux power drawn while disabled");

    phantom_zero_a: assert property (CFG_ACK |-> !CFG_RDATA[9] && !PHANTOM_FUNCTION_ENABLE)
        else $error("phantom function enable not zero");

    rsv_zero_a: assert property (CFG_ACK |-> !CFG_RDATA[15])
        else $error("reserved bit read nonzero");

    aux_sticky_a: assert property (
        @(posedge CLK_SYS) disable iff (!NRST_PWR)
        !(CFG_REQ && CFG_WE) |=> $stable(AUX_POWER_ENABLE))
        else $error("aux enable changed without write");

    // Configuration answer stands one cycle and is empty otherwise
    ack_pulse_a: assert property (!CFG_REQ |=> !CFG_ACK)
        else $error("acknowledge without a request");

    rdata_idle_a: assert property (!(CFG_REQ && !CFG_WE && hit) |=> CFG_RDATA == 32'h0)
        else $error("read data outside a hitting read");

    // Written fields follow the write, and nothing else moves them
    nsp_write_a: assert property (
        cfg_wr_hi_s |=> NO_SNOOP_PERMIT == $past(CFG_WDATA[11]))
        else $error("no-snoop permit did not take written value");

    fld_hold_a: assert property (
        !wr_hi |=> $stable(READ_REQUEST_SIZE_LIMIT) && $stable(NO_SNOOP_PERMIT))
        else $error("field changed without a hitting write");

    aux_write_a: assert property (
        @(posedge CLK_SYS) disable iff (!NRST_PWR)
        cfg_wr_hi_s |=> AUX_POWER_ENABLE == $past(CFG_WDATA[10]))
        else $error("aux enable did not take written value");

    // Ordinary reset leaves the size limit and no-snoop permit at their defaults
    rst_val_a: assert property (
        $rose(NRST) |-> READ_REQUEST_SIZE_LIMIT == `PDC_RRS_RST
        && NO_SNOOP_PERMIT == `PDC_NSP_RST && !TX_VALID && !CFG_ACK)
        else $error("fields not at defaults after reset");

    // Splitter takes a request, refuses more, then shows the first piece
    rd_busy_a: assert property (rd_take_s |=> !RD_REQ_READY)
        else $error("request taken while pieces remain");

    tx_first_a: assert property (
        rd_take_s ##0 !TX_VALID |-> ##2 TX_VALID && TX_ADDR == $past(RD_REQ_ADDR, 2))
        else $error("first piece missing or at wrong address");

    tx_bound_a: assert property (
        TX_VALID |-> {1'b0, TX_ADDR[5:0]} + TX_LEN <= 7'h40)
        else $error("outbound read crosses a 64-byte line");

    zero_drop_a: assert property (rd_zero_s |=> RD_REQ_READY)
        else $error("zero-length request was not dropped");

    // Received attribute copy holds between received packets
    rx_hold_a: assert property (!RX_VALID |=> !RX_VALID_OUT && $stable(RX_ATTR_OUT))
        else $error("received attribute changed while idle");

endmodule : pdc_port_devctrl

`default_nettype wire

// File: testbench/pdc_tx_sink.sv
// Downstream sink for outbound read pieces; ready every cycle or every other cycle.
// Assumes the port's transmit handshake on the same clock and reset.
`default_nettype none

module pdc_tx_sink (
    input wire logic clk,
    input wire logic nrst,
    input wire logic slow,
    input wire logic clr,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [31:0] tx_addr,
    input wire logic [6:0] tx_len,
    input wire logic tx_ns,
    output logic [15:0] bytes_q,
    output logic [7:0] pieces_q,
    output logic bad_q,
    output logic ns_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog_q;
    logic [31:0] next_q;

    // Stalling mode withholds ready on alternate cycles
    assign tx_ready = slow ? tog_q : 1'b1;

    // Tally accepted pieces; flag oversize, 64-byte crossing or address gaps
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {tog_q, bytes_q, pieces_q, bad_q, ns_q, next_q} <= '0;
        end else if (clr) begin
            {bytes_q, pieces_q, bad_q, ns_q} <= '0;
        end else begin
            tog_q <= ~tog_q;
            if (tx_valid && tx_ready) begin
                bytes_q <= bytes_q + {9'h000, tx_len};
                pieces_q <= pieces_q + 8'h01;
                ns_q <= ns_q | tx_ns;
                next_q <= tx_addr + {25'h0000000, tx_len};
                if (tx_len == 7'h00 || tx_len > 7'h40) bad_q <= 1'b1;
                if ({2'b00, tx_addr[5:0]} + {1'b0, tx_len} > 8'h40) bad_q <= 1'b1;
                if (pieces_q != 8'h00 && tx_addr != next_q) bad_q <= 1'b1;
            end
        end
    end
endmodule : pdc_tx_sink

`default_nettype wire

// File: testbench/test_pcie_root_port_device_control.sv
// Self-checking bench of the port device control register and its read shaping.
// Assumes the design under rtl/ and the sink model beside this file.
`default_nettype none

module test_pcie_root_port_device_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] DEV = 5'h03;
    logic CLK_SYS, NRST, NRST_PWR, CFG_REQ, CFG_WE, CFG_ACK;
    logic [4:0] CFG_DEV;
    logic [2:0] CFG_FUNC, READ_REQUEST_SIZE_LIMIT, AUX_CURRENT, AUX_POWER_ALLOC;
    logic [11:0] CFG_OFFSET;
    logic [3:0] CFG_BE;
    logic [31:0] CFG_WDATA, CFG_RDATA, RD_REQ_ADDR, TX_ADDR;
    logic NO_SNOOP_PERMIT, AUX_POWER_ENABLE, PHANTOM_FUNCTION_ENABLE, RD_REQ_VALID;
    logic RD_REQ_READY, RD_REQ_NS_OK, TX_VALID, TX_READY, TX_NO_SNOOP, TX_SNOOP;
    logic [12:0] RD_REQ_LEN;
    logic [6:0] TX_LEN;
    logic RX_VALID, RX_VALID_OUT, snk_slow, snk_clr, snk_bad, snk_ns;
    logic [1:0] RX_ATTR_IN, RX_ATTR_OUT;
    logic [15:0] snk_bytes;
    logic [7:0] snk_pieces;
    logic [31:0] rd;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;

    pdc_port_devctrl #(.PORT_DEV(DEV)) pdc_port_devctrl_inst (.CLK_SYS(CLK_SYS), .NRST(NRST),
        .NRST_PWR(NRST_PWR), .CFG_REQ(CFG_REQ), .CFG_WE(CFG_WE), .CFG_DEV(CFG_DEV),
        .CFG_FUNC(CFG_FUNC), .CFG_OFFSET(CFG_OFFSET), .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA),
        .CFG_ACK(CFG_ACK), .CFG_RDATA(CFG_RDATA),
        .READ_REQUEST_SIZE_LIMIT(READ_REQUEST_SIZE_LIMIT), .NO_SNOOP_PERMIT(NO_SNOOP_PERMIT),
        .AUX_POWER_ENABLE(AUX_POWER_ENABLE), .PHANTOM_FUNCTION_ENABLE(PHANTOM_FUNCTION_ENABLE),
        .AUX_CURRENT(AUX_CURRENT), .AUX_POWER_ALLOC(AUX_POWER_ALLOC),
        .RD_REQ_VALID(RD_REQ_VALID), .RD_REQ_READY(RD_REQ_READY), .RD_REQ_ADDR(RD_REQ_ADDR),
        .RD_REQ_LEN(RD_REQ_LEN), .RD_REQ_NS_OK(RD_REQ_NS_OK), .TX_VALID(TX_VALID),
        .TX_READY(TX_READY), .TX_ADDR(TX_ADDR), .TX_LEN(TX_LEN), .TX_NO_SNOOP(TX_NO_SNOOP),
        .TX_SNOOP(TX_SNOOP), .RX_VALID(RX_VALID), .RX_ATTR_IN(RX_ATTR_IN),
        .RX_VALID_OUT(RX_VALID_OUT), .RX_ATTR_OUT(RX_ATTR_OUT));

    pdc_tx_sink pdc_tx_sink_inst (.clk(CLK_SYS), .nrst(NRST), .slow(snk_slow), .clr(snk_clr),
        .tx_valid(TX_VALID), .tx_ready(TX_READY), .tx_addr(TX_ADDR), .tx_len(TX_LEN),
        .tx_ns(TX_NO_SNOOP), .bytes_q(snk_bytes), .pieces_q(snk_pieces), .bad_q(snk_bad),
        .ns_q(snk_ns));

    // Clock of 4 ns period
    initial begin
        CLK_SYS = 1'b0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end

    // Hang guard
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One configuration access; acknowledge is due one edge later
    task automatic cfg(input logic we, input logic [4:0] dv, input logic [11:0] off,
        input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rdv);
        @(posedge CLK_SYS);
        #1;
        CFG_REQ = 1'b1;
        CFG_WE = we;
        CFG_DEV = dv;
        CFG_OFFSET = off;
        CFG_BE = be;
        CFG_WDATA = wd;
        @(posedge CLK_SYS);
        #1;
        CFG_REQ = 1'b0;
        chk({31'h0, CFG_ACK}, 32'h1);
        rdv = CFG_RDATA;
    endtask : cfg

    task automatic wr(input logic [31:0] wd);
        cfg(1'b1, DEV, 12'h074, 4'hf, wd, rd);
    endtask : wr

    task automatic rdchk(input logic [31:0] exp);
        cfg(1'b0, DEV, 12'h074, 4'hf, 32'h0, rd);
        chk(rd, exp);
    endtask : rdchk

    // Hand one read request to the splitter and wait for all its bytes
    task automatic rd_req(input logic [31:0] a, input logic [12:0] n, input logic ns);
        int k;
        k = 0;
        while (RD_REQ_READY !== 1'b1 && k < 200) begin
            @(posedge CLK_SYS);
            #1;
            k++;
        end
        RD_REQ_VALID = 1'b1;
        RD_REQ_ADDR = a;
        RD_REQ_LEN = n;
        RD_REQ_NS_OK = ns;
        snk_clr = 1'b1;
        @(posedge CLK_SYS);
        #1;
        RD_REQ_VALID = 1'b0;
        snk_clr = 1'b0;
        chk({31'h0, RD_REQ_READY}, 32'h0);
        k = 0;
        while (snk_bytes != {3'h0, n} && k < 2000) begin
            @(posedge CLK_SYS);
            #1;
            k++;
        end
        chk({16'h0, snk_bytes}, {19'h0, n});
        chk(TX_ADDR + {25'h0, TX_LEN}, a + {19'h0, n});
        chk({31'h0, snk_bad}, 32'h0);
    endtask : rd_req

    task automatic t_reset();
        rdchk(32'h0000_5800);
        cfg(1'b0, DEV + 5'h01, 12'h074, 4'hf, 32'h0, rd);
        chk(rd, 32'h0);
        cfg(1'b0, DEV, 12'h070, 4'hf, 32'h0, rd);
        chk(rd, 32'h0);
        CFG_FUNC = 3'h1;
        cfg(1'b0, DEV, 12'h074, 4'hf, 32'h0, rd);
        chk(rd, 32'h0);
        cfg(1'b1, DEV, 12'h074, 4'hf, 32'h0, rd);
        CFG_FUNC = 3'h0;
        cfg(1'b1, DEV + 5'h01, 12'h074, 4'hf, 32'h0, rd);
        rdchk(32'h0000_5800);
        $display("test reset done");
    endtask : t_reset

    task automatic t_mask();
        wr(32'hffff_ffff);
        rdchk(32'h0000_7c00);
        chk({31'h0, PHANTOM_FUNCTION_ENABLE}, 32'h0);
        chk({31'h0, NO_SNOOP_PERMIT}, 32'h1);
        cfg(1'b1, DEV, 12'h074, 4'hd, 32'h0, rd);
        rdchk(32'h0000_7c00);
        wr(32'h0);
        rdchk(32'h0);
        chk({31'h0, NO_SNOOP_PERMIT}, 32'h0);
        $display("test mask done");
    endtask : t_mask

    task automatic t_codes();
        for (int i = 0; i < 8; i++) begin
            wr({17'h0, i[2:0], 12'h800});
            rdchk({17'h0, i[2:0], 12'h800});
            chk({29'h0, READ_REQUEST_SIZE_LIMIT}, i);
        end
        $display("test codes done");
    endtask : t_codes

    task automatic t_split();
        wr(32'h0000_0800);
        snk_slow = 1'b1;
        rd_req(32'h0000_0130, 13'd200, 1'b1);
        chk({24'h0, snk_pieces}, 32'h4);
        chk({31'h0, snk_ns}, 32'h1);
        snk_slow = 1'b0;
        rd_req(32'h0000_0200, 13'd64, 1'b0);
        chk({31'h0, snk_ns}, 32'h0);
        wr(32'h0000_5000);
        rd_req(32'h0000_1000, 13'd4096, 1'b1);
        chk({24'h0, snk_pieces}, 32'h40);
        chk({31'h0, snk_ns}, 32'h0);
        RD_REQ_VALID = 1'b1;
        RD_REQ_LEN = 13'h000;
        @(posedge CLK_SYS);
        #1;
        RD_REQ_VALID = 1'b0;
        @(posedge CLK_SYS);
        #1;
        chk({30'h0, RD_REQ_READY, TX_VALID}, 32'h2);
        chk({31'h0, TX_SNOOP}, 32'h0);
        $display("test split done");
    endtask : t_split

    task automatic t_rx();
        wr(32'h0000_0800);
        for (int i = 0; i < 4; i++) begin
            RX_VALID = 1'b1;
            RX_ATTR_IN = i[1:0];
            @(posedge CLK_SYS);
            #1;
            chk({29'h0, RX_VALID_OUT, RX_ATTR_OUT}, {29'h0, 1'b1, i[1:0]});
        end
        RX_VALID = 1'b0;
        $display("test rx done");
    endtask : t_rx

    task automatic t_aux();
        AUX_CURRENT = 3'h5;
        wr(32'h0000_0400);
        @(posedge CLK_SYS);
        #1;
        chk({28'h0, AUX_POWER_ENABLE, AUX_POWER_ALLOC}, 32'hd);
        NRST = 1'b0;
        repeat (2) @(posedge CLK_SYS);
        #1;
        NRST = 1'b1;
        rdchk(32'h0000_5c00);
        NRST_PWR = 1'b0;
        repeat (2) @(posedge CLK_SYS);
        #1;
        NRST_PWR = 1'b1;
        chk({28'h0, AUX_POWER_ENABLE, AUX_POWER_ALLOC}, 32'h0);
        wr(32'h0000_0400);
        wr(32'h0);
        @(posedge CLK_SYS);
        #1;
        chk({28'h0, AUX_POWER_ENABLE, AUX_POWER_ALLOC}, 32'h0);
        $display("test aux done");
    endtask : t_aux

    // Main sequence
    initial begin
        {NRST, NRST_PWR, CFG_REQ, CFG_WE, RD_REQ_VALID, RD_REQ_NS_OK, RX_VALID} = '0;
        {snk_slow, snk_clr, CFG_DEV, CFG_FUNC, CFG_OFFSET, CFG_BE, CFG_WDATA} = '0;
        {RD_REQ_ADDR, RD_REQ_LEN, RX_ATTR_IN, AUX_CURRENT} = '0;
        repeat (2) @(posedge CLK_SYS);
        #1;
        NRST = 1'b1;
        NRST_PWR = 1'b1;
        t_reset();
        t_mask();
        t_codes();
        t_split();
        t_rx();
        t_aux();
        print_verdict();
    end
endmodule : test_pcie_root_port_device_control

`default_nettype wire
